/* dbgev_pins.sv */
`default_nettype none
// How it works
// - after reset all emulation pins are inputs until software selects emulation or sets a gpio output enable
// - emulation mode: access size pins show current microcontroller access size
// - otherwise access size pins are ordinary gpio
// - emulation mode: exec state pins show microcontroller pipeline status
// - otherwise exec state pins are ordinary gpio
// - location select high moves debug events to alternate pins, disables dedicated
// - converter pulls a debug event line low; that core enters debug mode
// - microcontroller drives its event line exactly three cycles on debug entry
// - signal processor drives its event line exactly three cycles on debug entry
module dbgev_pins
    import dbgev_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // core side
    input wire logic [dbgev_pkg::DBGEV_SIZE_W-1:0] mcu_acc_size_i,
    input wire logic [dbgev_pkg::DBGEV_EXEC_W-1:0] mcu_exec_state_i,
    input wire logic mcu_brk_hit_i,
    input wire logic dsp_brk_hit_i,
    input wire logic mcu_resume_i,
    input wire logic dsp_resume_i,
    output logic mcu_debug_mode_o,
    output logic dsp_debug_mode_o,
    output logic mcu_debug_enter_o,
    output logic dsp_debug_enter_o,
    // emulation pin control from software
    input wire logic size_emu_sel_i,
    input wire logic exec_emu_sel_i,
    input wire logic [dbgev_pkg::DBGEV_SIZE_W-1:0] size_gpio_out_i,
    input wire logic [dbgev_pkg::DBGEV_SIZE_W-1:0] size_gpio_oe_i,
    input wire logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_gpio_out_i,
    input wire logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_gpio_oe_i,
    output logic [dbgev_pkg::DBGEV_SIZE_W-1:0] size_gpio_in_o,
    output logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_gpio_in_o,
    // emulation pins
    input wire logic [dbgev_pkg::DBGEV_SIZE_W-1:0] access_size_pins_i,
    output logic [dbgev_pkg::DBGEV_SIZE_W-1:0] access_size_pins_o,
    output logic [dbgev_pkg::DBGEV_SIZE_W-1:0] access_size_pins_oe_o,
    input wire logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_state_pins_i,
    output logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_state_pins_o,
    output logic [dbgev_pkg::DBGEV_EXEC_W-1:0] exec_state_pins_oe_o,
    // debug event pins, dedicated and alternate locations
    input wire logic pin_location_select_i,
    input wire logic mcu_debug_event_n_i,
    output logic mcu_debug_event_n_o,
    output logic mcu_debug_event_n_oe_o,
    input wire logic dsp_debug_event_n_i,
    output logic dsp_debug_event_n_o,
    output logic dsp_debug_event_n_oe_o,
    input wire logic mcu_debug_event_alt_n_i,
    output logic mcu_debug_event_alt_n_o,
    output logic mcu_debug_event_alt_n_oe_o,
    input wire logic dsp_debug_event_alt_n_i,
    output logic dsp_debug_event_alt_n_o,
    output logic dsp_debug_event_alt_n_oe_o
);
    // location select, four event lines, then the two emulation pin groups
    localparam int unsigned SYNC_W = 5 + DBGEV_SIZE_W + DBGEV_EXEC_W;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [DBGEV_SIZE_W-1:0] size_out;
        logic [DBGEV_SIZE_W-1:0] size_oe;
        logic [DBGEV_EXEC_W-1:0] exec_out;
        logic [DBGEV_EXEC_W-1:0] exec_oe;
        logic [DBGEV_SIZE_W-1:0] size_in;
        logic [DBGEV_EXEC_W-1:0] exec_in;
        logic mcu_ded_oe;
        logic mcu_alt_oe;
        logic dsp_ded_oe;
        logic dsp_alt_oe;
        logic mcu_mode;
        logic dsp_mode;
        logic mcu_enter;
        logic dsp_enter;
    } dbgev_pins_t;

    dbgev_pins_t s_r;
    dbgev_pins_t s_nxt;

    logic [SYNC_W-1:0] raw_pins;
    logic loc_alt;
    logic mcu_low;
    logic dsp_low;
    logic mcu_pull;
    logic dsp_pull;
    logic mcu_halted;
    logic dsp_halted;
    logic mcu_enter;
    logic dsp_enter;

    // every pin is asynchronous to ref_clk_i; two flops before use
    assign raw_pins = {pin_location_select_i, mcu_debug_event_n_i, dsp_debug_event_n_i,
                       mcu_debug_event_alt_n_i, dsp_debug_event_alt_n_i,
                       access_size_pins_i, exec_state_pins_i};

    // the second stage only; first stage feeds nothing else
    assign loc_alt = s_r.sync2[SYNC_W-1];
    // dedicated pins ignored when the alternate location is chosen
    assign mcu_low = loc_alt ? !s_r.sync2[SYNC_W-4] : !s_r.sync2[SYNC_W-2];
    assign dsp_low = loc_alt ? !s_r.sync2[SYNC_W-5] : !s_r.sync2[SYNC_W-3];

    dbgev_core_end u_mcu (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .line_low_i(mcu_low),
        .brk_hit_i(mcu_brk_hit_i),
        .resume_i(mcu_resume_i),
        .enable_i(1'b1),
        .pull_low_o(mcu_pull),
        .halted_o(mcu_halted),
        .enter_o(mcu_enter)
    );

    dbgev_core_end u_dsp (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .line_low_i(dsp_low),
        .brk_hit_i(dsp_brk_hit_i),
        .resume_i(dsp_resume_i),
        .enable_i(1'b1),
        .pull_low_o(dsp_pull),
        .halted_o(dsp_halted),
        .enter_o(dsp_enter)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = raw_pins;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.size_in = s_r.sync2[DBGEV_EXEC_W +: DBGEV_SIZE_W];
        s_nxt.exec_in = s_r.sync2[0 +: DBGEV_EXEC_W];
        if (size_emu_sel_i) begin
            s_nxt.size_out = mcu_acc_size_i;
            s_nxt.size_oe = '1;
        end else begin
            s_nxt.size_out = size_gpio_out_i;
            s_nxt.size_oe = size_gpio_oe_i;
        end
        if (exec_emu_sel_i) begin
            s_nxt.exec_out = mcu_exec_state_i;
            s_nxt.exec_oe = '1;
        end else begin
            s_nxt.exec_out = exec_gpio_out_i;
            s_nxt.exec_oe = exec_gpio_oe_i;
        end
        // one-cycle pin latency is shared by both locations; pulse width kept
        s_nxt.mcu_ded_oe = mcu_pull && !loc_alt;
        s_nxt.mcu_alt_oe = mcu_pull && loc_alt;
        s_nxt.dsp_ded_oe = dsp_pull && !loc_alt;
        s_nxt.dsp_alt_oe = dsp_pull && loc_alt;
        s_nxt.mcu_mode = mcu_halted;
        s_nxt.dsp_mode = dsp_halted;
        s_nxt.mcu_enter = mcu_enter;
        s_nxt.dsp_enter = dsp_enter;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
            s_r.size_out <= DBGEV_SIZE_GPI;
            s_r.exec_out <= DBGEV_EXEC_GPI;
            // idle level of pulled-up lines; a zero here would fake a request
            s_r.sync1 <= '1;
            s_r.sync2 <= '1;
        end else if (clk_en_i) begin
            s_r <= s_nxt;
        end
    end

    assign access_size_pins_o = s_r.size_out;
    assign access_size_pins_oe_o = s_r.size_oe;
    assign exec_state_pins_o = s_r.exec_out;
    assign exec_state_pins_oe_o = s_r.exec_oe;
    assign size_gpio_in_o = s_r.size_in;
    assign exec_gpio_in_o = s_r.exec_in;
    // open drain: data always low, only the enable moves
    assign mcu_debug_event_n_o = 1'b0;
    assign dsp_debug_event_n_o = 1'b0;
    assign mcu_debug_event_alt_n_o = 1'b0;
    assign dsp_debug_event_alt_n_o = 1'b0;
    assign mcu_debug_event_n_oe_o = s_r.mcu_ded_oe;
    assign mcu_debug_event_alt_n_oe_o = s_r.mcu_alt_oe;
    assign dsp_debug_event_n_oe_o = s_r.dsp_ded_oe;
    assign dsp_debug_event_alt_n_oe_o = s_r.dsp_alt_oe;
    assign mcu_debug_mode_o = s_r.mcu_mode;
    assign dsp_debug_mode_o = s_r.dsp_mode;
    assign mcu_debug_enter_o = s_r.mcu_enter;
    assign dsp_debug_enter_o = s_r.dsp_enter;
endmodule : dbgev_pins
`default_nettype wire

/* dbgev_pkg.sv */
`default_nettype none
package dbgev_pkg;
    localparam int unsigned DBGEV_ACK_CYCLES = 3;
    localparam logic [1:0] DBGEV_ACK_CNT_W_ONE = 2'h1;
    localparam logic [1:0] DBGEV_ACK_LOAD = 2'(DBGEV_ACK_CYCLES);
    localparam int unsigned DBGEV_SIZE_W = 2;
    localparam int unsigned DBGEV_EXEC_W = 4;
    localparam logic [1:0] DBGEV_SIZE_GPI = 2'h0;
    localparam logic [3:0] DBGEV_EXEC_GPI = 4'h0;

    typedef enum logic [1:0] {
        DBGEV_RUN = 2'b00,
        DBGEV_ACK = 2'b01,
        DBGEV_HALT = 2'b10
    } dbgev_state_t;
endpackage : dbgev_pkg
`default_nettype wire

/* dbgev_core_end.sv */
`default_nettype none
module dbgev_core_end
    import dbgev_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // requests, already synchronised
    input wire logic line_low_i,
    input wire logic brk_hit_i,
    input wire logic resume_i,
    input wire logic enable_i,
    // results
    output logic pull_low_o,
    output logic halted_o,
    output logic enter_o
);
    typedef struct packed {
        dbgev_state_t st;
        logic [1:0] cnt;
        logic pull;
        logic enter;
    } dbgev_ce_t;

    dbgev_ce_t s_r;
    dbgev_ce_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.enter = 1'b0;
        case (s_r.st)
            DBGEV_RUN: begin
                // own pulse not yet driving, so a low line is a real request
                if (enable_i && (line_low_i || brk_hit_i)) begin
                    s_nxt.st = DBGEV_ACK;
                    s_nxt.cnt = DBGEV_ACK_LOAD;
                    s_nxt.pull = 1'b1;
                    s_nxt.enter = 1'b1;
                end
            end
            DBGEV_ACK: begin
                if (s_r.cnt == DBGEV_ACK_CNT_W_ONE) begin
                    s_nxt.pull = 1'b0;
                    s_nxt.st = DBGEV_HALT;
                end else begin
                    s_nxt.cnt = s_r.cnt - DBGEV_ACK_CNT_W_ONE;
                end
            end
            DBGEV_HALT: begin
                // line may still be held low by the converter; wait for release
                if (resume_i && !line_low_i) begin
                    s_nxt.st = DBGEV_RUN;
                end
            end
            default: begin
                s_nxt.st = DBGEV_RUN;
                s_nxt.pull = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '{st: DBGEV_RUN, cnt: 2'h0, pull: 1'b0, enter: 1'b0};
        end else if (clk_en_i) begin
            s_r <= s_nxt;
        end
    end

    assign pull_low_o = s_r.pull;
    assign halted_o = (s_r.st != DBGEV_RUN);
    assign enter_o = s_r.enter;
endmodule : dbgev_core_end
`default_nettype wire

/* dbgev_pins_monitor.sv */
`default_nettype none
module dbgev_pins_monitor
    import dbgev_pkg::*;
(
    // grouped to keep the checker short
    input wire logic ref_clk_i, rst_b_i, clk_en_i, size_emu_sel_i, exec_emu_sel_i, pin_location_select_i,
    input wire logic [1:0] mcu_acc_size_i, size_gpio_out_i, size_gpio_oe_i, access_size_pins_o, access_size_pins_oe_o,
    input wire logic [3:0] mcu_exec_state_i, exec_gpio_out_i, exec_gpio_oe_i, exec_state_pins_o, exec_state_pins_oe_o,
    input wire logic mcu_debug_event_n_o, mcu_debug_event_n_oe_o, dsp_debug_event_n_o, dsp_debug_event_n_oe_o,
    input wire logic mcu_debug_event_alt_n_o, mcu_debug_event_alt_n_oe_o, dsp_debug_event_alt_n_o,
    input wire logic dsp_debug_event_alt_n_oe_o, mcu_debug_enter_o, dsp_debug_enter_o
);
    wire logic mcu_pull = mcu_debug_event_n_oe_o | mcu_debug_event_alt_n_oe_o;
    wire logic dsp_pull = dsp_debug_event_n_oe_o | dsp_debug_event_alt_n_oe_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_gpi;
        $rose(rst_b_i) |-> access_size_pins_oe_o == 2'h0 && exec_state_pins_oe_o == 4'h0;
    endproperty
    a_gpi: assert property (p_gpi) else $error("emulation pins driven after reset");
    property p_sz_emu;
        clk_en_i && size_emu_sel_i |=> access_size_pins_oe_o == 2'h3 && access_size_pins_o == $past(mcu_acc_size_i);
    endproperty
    a_sz_emu: assert property (p_sz_emu) else $error("size pins do not show access size");
    property p_sz_gpio;
        clk_en_i && !size_emu_sel_i |=> access_size_pins_oe_o == $past(size_gpio_oe_i)
            && access_size_pins_o == $past(size_gpio_out_i);
    endproperty
    a_sz_gpio: assert property (p_sz_gpio) else $error("size pins not acting as gpio");
    property p_ex_emu;
        clk_en_i && exec_emu_sel_i |=> exec_state_pins_oe_o == 4'hF && exec_state_pins_o == $past(mcu_exec_state_i);
    endproperty
    a_ex_emu: assert property (p_ex_emu) else $error("exec pins do not show pipeline state");
    property p_ex_gpio;
        clk_en_i && !exec_emu_sel_i |=> exec_state_pins_oe_o == $past(exec_gpio_oe_i)
            && exec_state_pins_o == $past(exec_gpio_out_i);
    endproperty
    a_ex_gpio: assert property (p_ex_gpio) else $error("exec pins not acting as gpio");
    property p_alt;
        pin_location_select_i [*6] |-> !mcu_debug_event_n_oe_o && !dsp_debug_event_n_oe_o;
    endproperty
    a_alt: assert property (p_alt) else $error("dedicated event pin pulled while disabled");
    property p_mcu_ack;
        $rose(mcu_pull) |-> mcu_debug_enter_o ##1 mcu_pull [*2] ##1 !mcu_pull;
    endproperty
    a_mcu_ack: assert property (p_mcu_ack) else $error("mcu event pulse not three cycles");
    property p_dsp_ack;
        $rose(dsp_pull) |-> dsp_debug_enter_o ##1 dsp_pull [*2] ##1 !dsp_pull;
    endproperty
    a_dsp_ack: assert property (p_dsp_ack) else $error("dsp event pulse not three cycles");
    property p_od;
        !(mcu_debug_event_n_o | dsp_debug_event_n_o | mcu_debug_event_alt_n_o | dsp_debug_event_alt_n_o);
    endproperty
    a_od: assert property (p_od) else $error("event line driven high");
endmodule : dbgev_pins_monitor
bind dbgev_pins dbgev_pins_monitor mon (.*);
`default_nettype wire

/* dbgev_conv_model.sv */
`default_nettype none
module dbgev_conv_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // request and hold length
    input wire logic req_i,
    input wire logic [3:0] hold_i,
    // open drain pull
    output logic pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 4'h0;
        end else if (req_i) begin
            cnt_r <= hold_i;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // only ever pulls low, the pull-up gives the high level
    assign pull_o = cnt_r != 4'h0;
endmodule : dbgev_conv_model
`default_nettype wire

/* dbgev_pins_bench.sv */
`default_nettype none
module dbgev_pins_bench;
    import dbgev_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, rst_b_i, clk_en_i, mcu_brk_hit_i, dsp_brk_hit_i, mcu_resume_i, dsp_resume_i, req, tgt_dsp;
    logic size_emu_sel_i, exec_emu_sel_i, pin_location_select_i, mcu_debug_mode_o, dsp_debug_mode_o, cpull;
    logic mcu_debug_enter_o, dsp_debug_enter_o, mcu_debug_event_n_o, mcu_debug_event_n_oe_o, dsp_debug_event_n_o;
    logic dsp_debug_event_n_oe_o, mcu_debug_event_alt_n_o, mcu_debug_event_alt_n_oe_o, dsp_debug_event_alt_n_o;
    logic dsp_debug_event_alt_n_oe_o;
    logic [1:0] mcu_acc_size_i, size_gpio_out_i, size_gpio_oe_i, size_gpio_in_o, access_size_pins_o, access_size_pins_oe_o;
    logic [3:0] mcu_exec_state_i, exec_gpio_out_i, exec_gpio_oe_i, exec_gpio_in_o, exec_state_pins_o, exec_state_pins_oe_o;
    logic [3:0] hold;
    int miscompares, checked;
    // undriven pins float to their pull-ups
    wire logic [1:0] access_size_pins_i = access_size_pins_o | ~access_size_pins_oe_o;
    wire logic [3:0] exec_state_pins_i = exec_state_pins_o | ~exec_state_pins_oe_o;
    wire logic cm = cpull & !tgt_dsp;
    wire logic cd = cpull & tgt_dsp;
    wire logic mcu_debug_event_n_i = !(mcu_debug_event_n_oe_o | cm & !pin_location_select_i);
    wire logic dsp_debug_event_n_i = !(dsp_debug_event_n_oe_o | cd & !pin_location_select_i);
    wire logic mcu_debug_event_alt_n_i = !(mcu_debug_event_alt_n_oe_o | cm & pin_location_select_i);
    wire logic dsp_debug_event_alt_n_i = !(dsp_debug_event_alt_n_oe_o | cd & pin_location_select_i);
    dbgev_pins uut (.*);
    dbgev_conv_model conv (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .hold_i(hold), .pull_o(cpull));
    task automatic chk(input string what, input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic emu_pins(input logic sel);
        @(posedge ref_clk_i);
        size_emu_sel_i <= sel;
        exec_emu_sel_i <= sel;
        size_gpio_oe_i <= 2'h2;
        exec_gpio_oe_i <= 4'h9;
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("size_oe", {2'h0, access_size_pins_oe_o}, sel ? 4'h3 : 4'h2);
        chk("size_out", {2'h0, access_size_pins_o}, sel ? 4'h2 : 4'h1);
        chk("exec_oe", exec_state_pins_oe_o, sel ? 4'hF : 4'h9);
        chk("exec_out", exec_state_pins_o, sel ? 4'hA : 4'h5);
        chk("size_in", {2'h0, size_gpio_in_o}, sel ? 4'h2 : 4'h1);
        chk("exec_in", exec_gpio_in_o, sel ? 4'hA : 4'h7);
    endtask : emu_pins
    // long converter holds overlap the ack, so a retrigger would show as extra pulls
    task automatic ack(input logic dsp, input logic ext, input logic alt, input logic [3:0] len);
        int nd, na;
        nd = 0;
        na = 0;
        @(posedge ref_clk_i);
        pin_location_select_i <= alt;
        tgt_dsp <= dsp;
        hold <= len;
        repeat (8) @(posedge ref_clk_i);
        if (ext) req <= 1'b1; else if (dsp) dsp_brk_hit_i <= 1'b1; else mcu_brk_hit_i <= 1'b1;
        @(posedge ref_clk_i);
        {req, dsp_brk_hit_i, mcu_brk_hit_i} <= 3'h0;
        repeat (30) begin
            @(negedge ref_clk_i);
            nd += dsp ? dsp_debug_event_n_oe_o : mcu_debug_event_n_oe_o;
            na += dsp ? dsp_debug_event_alt_n_oe_o : mcu_debug_event_alt_n_oe_o;
        end
        chk("ded_pulls", nd[3:0], alt ? 4'h0 : 4'h3);
        chk("alt_pulls", na[3:0], alt ? 4'h3 : 4'h0);
        chk("in_debug", {3'h0, dsp ? dsp_debug_mode_o : mcu_debug_mode_o}, 4'h1);
        @(posedge ref_clk_i);
        {dsp_resume_i, mcu_resume_i} <= dsp ? 2'h2 : 2'h1;
        repeat (3) @(posedge ref_clk_i);
        {dsp_resume_i, mcu_resume_i} <= 2'h0;
        @(negedge ref_clk_i);
        chk("resumed", {3'h0, dsp ? dsp_debug_mode_o : mcu_debug_mode_o}, 4'h0);
    endtask : ack
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        miscompares++;
        stop_test();
    end
    initial begin
        {miscompares, checked} = '0;
        {rst_b_i, clk_en_i, mcu_brk_hit_i, dsp_brk_hit_i, mcu_resume_i, dsp_resume_i} = 6'h10;
        {size_emu_sel_i, exec_emu_sel_i, pin_location_select_i, req, tgt_dsp, hold} = 9'h2;
        {mcu_acc_size_i, mcu_exec_state_i, size_gpio_out_i, exec_gpio_out_i} = 12'hA95;
        {size_gpio_oe_i, exec_gpio_oe_i} = 6'h0;
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        chk("reset_oe", exec_state_pins_oe_o | {2'h0, access_size_pins_oe_o}, 4'h0);
        emu_pins(1'b0);
        emu_pins(1'b1);
        ack(1'b0, 1'b0, 1'b0, 4'h2);
        ack(1'b1, 1'b0, 1'b0, 4'h2);
        ack(1'b0, 1'b1, 1'b0, 4'h2);
        ack(1'b1, 1'b1, 1'b1, 4'h5);
        ack(1'b0, 1'b1, 1'b1, 4'h5);
        stop_test();
    end
endmodule : dbgev_pins_bench
`default_nettype wire
